/* design/usr_shift_reg.sv */
`timescale 1ns/100ps
module usr_shift_reg
   import usr_pkg::*;
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        rst_n,
   // Control
   input  wire logic        clr_n,
   input  wire logic        mode_sel_hi,
   input  wire logic        mode_sel_lo,
   input  wire logic        shift_clk,
   // Data in
   input  wire logic        ser_in_right,
   input  wire logic        ser_in_left,
   input  wire logic [3:0]  par_in,
   // Register outputs
   output logic             reg_out_first,
   output logic             reg_out_second,
   output logic             reg_out_third,
   output logic             reg_out_last,
   // Change stream
   output logic             snap_room,
   output logic             snap_valid,
   input  wire logic        snap_ready,
   output logic [3:0]       snap_data
);

   //==============================================================
   // State
   logic [USR_REG_W-1:0] q;
   logic [USR_REG_W-1:0] next_q;
   logic                 clk_prev;
   usr_mode_t            mode;

   //==============================================================
   // Decode
   // The device clock is sampled on ref_clk; only its rising edge counts
   wire rise = shift_clk && !clk_prev;

   assign mode = usr_mode_t'({mode_sel_hi, mode_sel_lo});

   always_comb begin
      next_q = q;
      if (!clr_n) begin
         // Clear wins over every mode and does not wait for shift_clk
         next_q = USR_REG_CLR;
      end else if (rise) begin
         case (mode)
            USR_LOAD: next_q = par_in;
            USR_SHR:  next_q = {q[USR_BIT_LAST-1:USR_BIT_FIRST], ser_in_right};
            USR_SHL:  next_q = {ser_in_left, q[USR_BIT_LAST:USR_BIT_FIRST+1]};
            USR_HOLD: next_q = q;
            default:  next_q = q;
         endcase
      end
   end

   //==============================================================
   // Register
   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         q        <= USR_REG_RST;
         clk_prev <= USR_CLK_RST;
      end else begin
         q        <= next_q;
         clk_prev <= shift_clk;
      end
   end

   assign reg_out_first  = q[USR_BIT_FIRST];
   assign reg_out_second = q[USR_BIT_FIRST+1];
   assign reg_out_third  = q[USR_BIT_LAST-1];
   assign reg_out_last   = q[USR_BIT_LAST];

   //==============================================================
   // Change stream
   // Each new register value is offered once; a full buffer drops it
   // rather than stalling, since the register must never miss an edge
   usr_fifo #(
      .WIDTH (USR_REG_W),
      .DEPTH (USR_FIFO_D)
   ) u_fifo (
      .clk       (ref_clk),
      .rst_n     (rst_n),
      .in_valid  (next_q != q),
      .in_ready  (snap_room),
      .in_data   (next_q),
      .out_valid (snap_valid),
      .out_ready (snap_ready),
      .out_data  (snap_data)
   );

   //==============================================================
   // Checks
   a_clear_forces_low : assert property (@(posedge ref_clk) disable iff (!rst_n)
      !clr_n |=> q == USR_REG_CLR [*1])
      else $error("clear did not zero the register");

   a_clear_inactive : assert property (@(posedge ref_clk) disable iff (!rst_n)
      clr_n && !rise && q != '0 |=> q != '0)
      else $error("inactive clear disturbed the register");

   a_clock_low_hold : assert property (@(posedge ref_clk) disable iff (!rst_n)
      clr_n && !shift_clk |=> $stable(q))
      else $error("register moved while clock low");

   a_clock_high_hold : assert property (@(posedge ref_clk) disable iff (!rst_n)
      clr_n && shift_clk && clk_prev ##1 clr_n [*1] |-> $stable(q) or !clr_n)
      else $error("register moved without a rising clock");

   a_load_parallel : assert property (@(posedge ref_clk) disable iff (!rst_n)
      clr_n && rise && mode_sel_hi && mode_sel_lo |=> q == $past(par_in))
      else $error("parallel load wrong");

   a_shift_right : assert property (@(posedge ref_clk) disable iff (!rst_n)
      clr_n && rise && !mode_sel_hi && mode_sel_lo
      |=> q == {$past(q[2:0]), $past(ser_in_right)})
      else $error("shift right wrong");

   a_shift_left : assert property (@(posedge ref_clk) disable iff (!rst_n)
      clr_n && rise && mode_sel_hi && !mode_sel_lo
      |=> q == {$past(ser_in_left), $past(q[3:1])})
      else $error("shift left wrong");

   a_shift_no_par : assert property (@(posedge ref_clk) disable iff (!rst_n)
      clr_n && rise && (mode_sel_hi ^ mode_sel_lo) && par_in != q
      |=> q[3:1] == $past(q[2:0]) || q[2:0] == $past(q[3:1]))
      else $error("shift took parallel data");

   a_mode_hold : assert property (@(posedge ref_clk) disable iff (!rst_n)
      clr_n && !mode_sel_hi && !mode_sel_lo |=> $stable(q))
      else $error("hold mode changed the register");

   // A change must reach the buffer unless it is full; a full buffer drops it
   a_change_offered : assert property (@(posedge ref_clk) disable iff (!rst_n)
      next_q != q && snap_room |=> snap_valid)
      else $error("register change not buffered");

   a_quiet_no_word : assert property (@(posedge ref_clk) disable iff (!rst_n)
      next_q == q && !snap_valid |=> !snap_valid)
      else $error("buffer gained a word without a change");

endmodule

/* design/usr_pkg.sv */
//==============================================================
// Functional notes
// - Clear low forces all four outputs low
// - Clear high leaves the mode-selected behaviour
// - Clock held low keeps outputs unchanged
// - Change only on rising clock edge
// - Both selects high: rising edge loads parallel
// - Shift right: right serial enters first bit
// - Shift left: left serial enters last bit
// - Shifts ignore parallel inputs entirely
// - Both selects low: outputs held unchanged
package usr_pkg;

   //==============================================================
   // Sizes and positions
   localparam int         USR_REG_W     = 4;
   localparam int         USR_FIFO_D    = 16;
   localparam int         USR_BIT_FIRST = 0;
   localparam int         USR_BIT_LAST  = 3;
   localparam logic [3:0] USR_REG_RST   = 4'h0;
   localparam logic [3:0] USR_REG_CLR   = 4'h0;
   // Previous shift clock level after reset; high so a clock
   // already high at release is not taken as a rising edge
   localparam logic       USR_CLK_RST   = 1'b1;

   //==============================================================
   // Operating modes
   typedef enum logic [1:0] {
      USR_HOLD,
      USR_SHR,
      USR_SHL,
      USR_LOAD
   } usr_mode_t;

endpackage

/* design/usr_fifo.sv */
`timescale 1ns/100ps
module usr_fifo #(
   parameter int WIDTH = 4,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr;
   logic [AW-1:0]    rd_ptr;
   logic [AW:0]      count;
   logic [AW:0]      next_count;
   logic [AW-1:0]    next_rd_ptr;
   wire              push = in_valid && in_ready;
   wire              pop  = out_valid && out_ready;

   //==============================================================
   // Occupancy; both flags are flops so in_ready and out_valid leave registers
   assign next_count  = push && !pop ? count + 1'b1 :
                        pop && !push ? count - 1'b1 : count;
   assign next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         count     <= '0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         rd_ptr    <= next_rd_ptr;
         count     <= next_count;
         in_ready  <= next_count != (AW+1)'(DEPTH);
         out_valid <= next_count != '0;
      end
   end

   // Head word is registered; a push landing at the new head bypasses the array
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
      out_data <= push && wr_ptr == next_rd_ptr ? in_data : mem[next_rd_ptr];
   end

   a_fifo_count_bound : assert property (@(posedge clk) disable iff (!rst_n)
      count <= (AW+1)'(DEPTH))
      else $error("fifo occupancy above depth");

endmodule

/* verification/usr_consumer.sv */
`timescale 1ns/100ps
//==========
// Stream consumer
module usr_consumer (
   // Clock
   input  wire logic ref_clk,
   // Stream
   output logic      snap_ready,
   // Bench control
   input  wire logic stall
);
   // Random ready so pops come both back to back and spaced out
   initial begin
      snap_ready = 1'b0;
      forever @(posedge ref_clk) snap_ready <= !stall && ($urandom % 4 != 0);
   end
endmodule

/* verification/usr_bench.sv */
`timescale 1ns/100ps
module universal_shift_register_4bit_bench;
   logic       ref_clk, rst_n, clr_n, mode_sel_hi, mode_sel_lo, shift_clk;
   logic       ser_in_right, ser_in_left, stall, snap_room, snap_valid, snap_ready;
   logic       reg_out_first, reg_out_second, reg_out_third, reg_out_last;
   logic [3:0] par_in, snap_data, q, model;
   logic [3:0] wq[$];
   int         err_total, comparisons, cycles;

   assign q = {reg_out_last, reg_out_third, reg_out_second, reg_out_first};

   usr_shift_reg u_dut (.ref_clk, .rst_n, .clr_n, .mode_sel_hi, .mode_sel_lo,
      .shift_clk, .ser_in_right, .ser_in_left, .par_in, .reg_out_first,
      .reg_out_second, .reg_out_third, .reg_out_last, .snap_room, .snap_valid,
      .snap_ready, .snap_data);
   usr_consumer u_far (.ref_clk, .snap_ready, .stall);

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("[FAIL] %0t: got %h want %h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   //==========
   // Change stream monitor and watchdog
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 3000) begin
         err_total++;
         give_verdict();
      end else if (snap_valid && snap_ready) begin
         if (wq.size() == 0) begin
            err_total++;
            $display("[FAIL] %0t: stream word with none expected", $time);
         end else begin
            chk(snap_data, wq.pop_front());
         end
      end
   end

   //==========
   // Next register value from the mode table; clear overrides every mode
   function automatic logic [3:0] model_next(input logic [4:0] c, input logic [3:0] p,
                                            input logic [3:0] old);
      logic [3:0] nxt;
      case (c[3:2])
         2'b11: nxt = p;
         2'b01: nxt = {old[2:0], c[1]};
         2'b10: nxt = {c[0], old[3:1]};
         default: nxt = old;
      endcase
      if (!c[4]) nxt = 4'h0;
      return nxt;
   endfunction

   // One device clock pulse; c = {clr_n, hi, lo, ser_in_right, ser_in_left}
   task automatic op(input logic [4:0] c, input logic [3:0] p);
      logic [3:0] old, want;
      old = model;
      want = model_next(c, p, old);
      if (want != old) wq.push_back(want);
      model = want;
      {clr_n, mode_sel_hi, mode_sel_lo, ser_in_right, ser_in_left} = {1'b1, c[3:0]};
      shift_clk = 1'b0;
      par_in = p;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(q, old);
      clr_n = c[4];
      shift_clk = 1'b1;
      repeat (3) @(posedge ref_clk);
      #1;
      chk(q, want);
   endtask

   // Clear with the device clock standing high, so no edge can help it
   task automatic clr_idle;
      if (model != 4'h0) wq.push_back(4'h0);
      model = 4'h0;
      clr_n = 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(q, 4'h0);
   endtask

   // Bounded wait, since a stuck buffer must not hang the run
   task automatic drain;
      stall = 1'b0;
      for (int k = 0; k < 200 && snap_valid; k++) @(posedge ref_clk);
      repeat (2) @(posedge ref_clk);
      #1;
      chk({3'h0, snap_valid}, 4'h0);
      // Every expected word must have come out; a dropped one stays queued
      chk(4'(wq.size()), 4'h0);
   endtask

   initial begin
      {clr_n, mode_sel_hi, mode_sel_lo, ser_in_right, ser_in_left} = 5'h10;
      {shift_clk, stall, rst_n} = 3'h0;
      par_in = 4'h0;
      model = 4'h0;
      void'($urandom(37152));
      repeat (4) @(posedge ref_clk);
      #1 rst_n = 1'b1;
      chk(q, 4'h0);
      op(5'h1c, 4'hf);
      clr_idle();
      op(5'h14, 4'hf);
      op(5'h19, 4'h0);
      op(5'h0c, 4'h9);
      for (int i = 0; i < 60; i++) op({$urandom % 8 != 0, 4'($urandom)}, 4'($urandom));
      op(5'h0c, 4'h0);
      drain();
      stall = 1'b1;
      // Sixteen distinct changes fill the buffer exactly, none dropped
      for (int i = 0; i < 16; i++) op(5'h1c, i % 2 ? 4'h5 : 4'ha);
      chk({3'h0, snap_room}, 4'h0);
      drain();
      give_verdict();
   end
endmodule
